// [hdl/lbts_pkg.sv]
// Constants, register map and types of the LIN bit-timing and status block.
`default_nettype none
package lbts_pkg;
  // ==========================================================
  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQEN = 8'h08;
  localparam logic [7:0] ADDR_BTR = 8'h0c;
  localparam logic [7:0] ADDR_DIV = 8'h10;
  localparam logic [7:0] ADDR_ERR = 8'h14;
  localparam logic [7:0] ADDR_BYTE = 8'h18;
  // ==========================================================
  // Field positions.
  localparam int CTRL_ENA = 0;
  localparam int CTRL_MASTER = 1;
  localparam int BTR_DISR = 7;
  localparam int STS_RXOK = 0;
  localparam int STS_TXOK = 1;
  localparam int STS_IDOK = 2;
  localparam int STS_ERR = 3;
  localparam int STS_BUSY = 4;
  localparam int STS_IDST = 5;
  localparam int ERRB_SYNC = 5;
  localparam int ERRB_FRAME = 6;
  // ==========================================================
  // Reset values and the samples-per-bit floor.
  localparam logic [5:0] SPB_DEFAULT = 6'h20;
  localparam logic [5:0] SPB_MIN = 6'h08;
  localparam logic [11:0] DIV_RESET = 12'h000;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // ==========================================================
  // Header timing, in bits and percent.
  localparam int BRK_MIN_HALF_BITS = 21;
  localparam int BRK_MAX_BITS = 28;
  localparam int SYNC_BITS = 8;
  localparam int SYNC_EDGES = 5;
  localparam int TOL_PCT = 20;
  localparam int SPB_LO = (32 * (100 - TOL_PCT) + 99) / 100;
  localparam int SPB_HI = (32 * (100 + TOL_PCT)) / 100;
  localparam logic [10:0] SYNC_MIN_CNT = 11'(SPB_LO * SYNC_BITS);
  localparam logic [10:0] SYNC_MAX_CNT = 11'(SPB_HI * SYNC_BITS);
  // ==========================================================
  // Special identifiers and their status codes.
  localparam logic [5:0] ID_60 = 6'h3c;
  localparam logic [5:0] ID_61 = 6'h3d;
  localparam logic [5:0] ID_62 = 6'h3e;
  localparam logic [5:0] ID_63 = 6'h3f;
  localparam logic [2:0] IDST_NONE = 3'h0;
  localparam logic [2:0] IDST_60 = 3'h4;
  localparam logic [2:0] IDST_61 = 3'h5;
  localparam logic [2:0] IDST_62 = 3'h6;
  localparam logic [2:0] IDST_63 = 3'h7;
  // Header receiver states, Gray coded along the header path.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_BRK = 3'h1,
    ST_SYNC = 3'h3,
    ST_PIDW = 3'h2,
    ST_RESP = 3'h6
  } lbts_state_t;
endpackage
`default_nettype wire

// [hdl/lbts_core.sv]
// Bit timing, header resynchronisation and status/interrupt register of a LIN controller.
//
// Behaviour
// - Sample tick every divider+1 clocks; baud = clock / (samples-per-bit * (divider+1)).
// - Samples-per-bit is a 6-bit field, default 32.
// - Each received bit is the majority of three samples near mid-bit.
// - Waiting for a header, samples-per-bit is 32; BREAK starts resynchronisation.
// - BREAK shorter than 10.5 or longer than 28 bits is refused.
// - Samples-per-bit is taken from the 0x55 SYNCH field, then identifier sampled.
// - Accepts SYNCH within 20 percent, rounds new count to about 2 percent.
// - Adjusted count holds until response end, then returns to 32.
// - No resynchronisation while the node is a LIN master.
// - Resync-disable lets software write samples-per-bit; values below 8 are raised.
// - Identifier status reads 0xx for no special identifier, 110 for 62.
// - Error flag bit 3 shows error bits; writing one clears all of them.
// - Identifier flag sets on slave identifier or master header complete.
// - Bit 0 receive flag sets on response received, cleared by writing one.
`default_nettype none
module lbts_core
  import lbts_pkg::*;
#(
  parameter int DIV_W = 12,
  parameter int ERR_EXT_W = 5
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic linRxd,
  input wire logic txHeaderDone,
  input wire logic txRespDone,
  input wire logic rxRespDone,
  input wire logic respAbort,
  input wire logic txBusy,
  input wire logic [ERR_EXT_W-1:0] errSet,
  output logic [7:0] rxByte,
  output logic rxByteValid,
  output logic [5:0] samplesPerBit,
  output logic irq
);
  // ==========================================================
  // Registers and internal state.
  logic [2:0] rxSync_q, edgeCnt_q, samp_q, idStatus_q;
  logic rxLvl_q, rxPrev_q, wrPend_q;
  logic ctrlEna_q, ctrlMaster_q, resyncDisable_q;
  logic [DIV_W-1:0] baudDivider_q, preCnt_q;
  logic [5:0] spb_q, phase_q, mid, spbNew;
  lbts_state_t state_q;
  logic [10:0] runCnt_q, brkMin, brkMax;
  logic byteOn_q, byteDone, frameBad, sampleTick, busWr;
  logic [3:0] bitIdx_q, flags_q, irqEn_q, w1c;
  logic [7:0] shift_q, errDetail_q, lastByte_q, wrAddr_q, statusView;
  logic fall, rise, resyncOn, idEvt, syncOk, syncBad, brkOk, respEnd;
  // Majority of three samples.
  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction
  // Identifier status code of a received identifier.
  function automatic logic [2:0] idCode(input logic [5:0] id);
    case (id)
      ID_60: idCode = IDST_60;
      ID_61: idCode = IDST_61;
      ID_62: idCode = IDST_62;
      ID_63: idCode = IDST_63;
      default: idCode = IDST_NONE;
    endcase
  endfunction
  // ==========================================================
  // Receive pin synchroniser; the level moves once stages two and three agree.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rxSync_q <= 3'h7;
      rxLvl_q <= 1'b1;
      rxPrev_q <= 1'b1;
    end else if (ce) begin
      rxSync_q <= {rxSync_q[1:0], linRxd};
      if (rxSync_q[1] == rxSync_q[2]) begin
        rxLvl_q <= rxSync_q[2];
      end
      rxPrev_q <= rxLvl_q;
    end
  end
  assign fall = rxPrev_q & ~rxLvl_q;
  assign rise = ~rxPrev_q & rxLvl_q;
  // ==========================================================
  // Prescaler tick.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      preCnt_q <= '0;
    end else if (ce) begin
      if (preCnt_q >= baudDivider_q) begin
        preCnt_q <= '0;
      end else begin
        preCnt_q <= preCnt_q + 1'b1;
      end
    end
  end
  assign sampleTick = (preCnt_q >= baudDivider_q);
  // Header decode terms; a slave with resync allowed adjusts the count.
  // Master excluded.
  assign resyncOn = ctrlEna_q & ~ctrlMaster_q & ~resyncDisable_q;
  assign brkMin = 11'((11'(spb_q) * 11'(BRK_MIN_HALF_BITS) + 11'h001) >> 1);
  assign brkMax = 11'(11'(spb_q) * 11'(BRK_MAX_BITS));
  assign brkOk = (runCnt_q >= brkMin) && (runCnt_q <= brkMax);
  assign syncOk = (runCnt_q >= SYNC_MIN_CNT) && (runCnt_q <= SYNC_MAX_CNT);
  assign syncBad = (state_q == ST_SYNC) && fall && (edgeCnt_q == 3'(SYNC_EDGES - 1)) && !syncOk;
  assign spbNew = 6'((runCnt_q + 11'h004) >> 3);
  assign respEnd = rxRespDone | txRespDone | respAbort;
  assign idEvt = (state_q == ST_PIDW) && byteDone && !frameBad;
  // ==========================================================
  // Header receiver: BREAK, SYNCH, identifier, response.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      runCnt_q <= '0;
      edgeCnt_q <= '0;
    end else if (ce) begin
      if (!ctrlEna_q || ctrlMaster_q) begin
        state_q <= ST_IDLE;
      end else begin
        case (state_q)
          ST_IDLE: begin
            runCnt_q <= '0;
            if (fall) begin
              state_q <= ST_BRK;
            end
          end
          ST_BRK: begin
            if (rise) begin
              state_q <= brkOk ? ST_SYNC : ST_IDLE;
              runCnt_q <= '0;
              edgeCnt_q <= '0;
            end else if (sampleTick && runCnt_q != 11'h7ff) begin
              runCnt_q <= runCnt_q + 11'h001;
            end
          end
          ST_SYNC: begin
            if (fall) begin
              edgeCnt_q <= edgeCnt_q + 3'h1;
              if (edgeCnt_q == 3'h0) begin
                runCnt_q <= '0;
              end
              if (edgeCnt_q == 3'(SYNC_EDGES - 1)) begin
                state_q <= syncOk ? ST_PIDW : ST_IDLE;
              end
            end else if (edgeCnt_q != 3'h0 && sampleTick) begin
              if (runCnt_q == 11'h7ff) begin
                state_q <= ST_IDLE;
              end else begin
                runCnt_q <= runCnt_q + 11'h001;
              end
            end
          end
          ST_PIDW: begin
            if (byteDone) begin
              state_q <= frameBad ? ST_IDLE : ST_RESP;
            end
          end
          ST_RESP: begin
            if (respEnd) begin
              state_q <= ST_IDLE;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // Samples-per-bit count.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      spb_q <= SPB_DEFAULT;
    end else if (ce) begin
      if (busWr && wrAddr_q == ADDR_BTR && (hwdata[BTR_DISR] || !ctrlEna_q)) begin
        spb_q <= (hwdata[5:0] < SPB_MIN) ? SPB_MIN : hwdata[5:0];
      end else if (resyncOn && state_q == ST_SYNC && fall && syncOk
                   && edgeCnt_q == 3'(SYNC_EDGES - 1)) begin
        spb_q <= spbNew;
      end else if (resyncOn && state_q == ST_IDLE) begin
        spb_q <= SPB_DEFAULT;
      end
    end
  end
  assign mid = spb_q >> 1;
  // ==========================================================
  // Byte receiver for identifier and response bytes.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      byteOn_q <= 1'b0;
      phase_q <= '0;
      bitIdx_q <= '0;
      samp_q <= '0;
      shift_q <= '0;
    end else if (ce) begin
      if (!byteOn_q) begin
        if (fall && (state_q == ST_PIDW || state_q == ST_RESP)) begin
          byteOn_q <= 1'b1;
          phase_q <= '0;
          bitIdx_q <= '0;
        end
      end else if (state_q == ST_IDLE) begin
        byteOn_q <= 1'b0;
      end else if (sampleTick) begin
        if (phase_q == mid - 6'h01) begin
          samp_q[0] <= rxLvl_q;
        end
        if (phase_q == mid) begin
          samp_q[1] <= rxLvl_q;
        end
        if (phase_q == mid + 6'h01) begin
          samp_q[2] <= rxLvl_q;
        end
        if (phase_q >= spb_q - 6'h01) begin
          phase_q <= '0;
          bitIdx_q <= bitIdx_q + 4'h1;
          if (bitIdx_q == 4'h0 && maj3(samp_q)) begin
            byteOn_q <= 1'b0;
          end else if (bitIdx_q == 4'h9) begin
            byteOn_q <= 1'b0;
          end else if (bitIdx_q != 4'h0) begin
            shift_q <= {maj3(samp_q), shift_q[7:1]};
          end
        end else begin
          phase_q <= phase_q + 6'h01;
        end
      end
    end
  end
  assign byteDone = byteOn_q && sampleTick && (phase_q >= spb_q - 6'h01) && (bitIdx_q == 4'h9);
  assign frameBad = ~maj3(samp_q);
  // Received byte output.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rxByte <= '0;
      rxByteValid <= 1'b0;
      lastByte_q <= '0;
    end else if (ce) begin
      rxByteValid <= byteDone && !frameBad;
      if (byteDone && !frameBad) begin
        rxByte <= shift_q;
        lastByte_q <= shift_q;
      end
    end
  end
  // ==========================================================
  // Status flags; a set in the same cycle as a clear wins.
  assign w1c = (busWr && wrAddr_q == ADDR_STATUS) ? hwdata[3:0] : 4'h0;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flags_q <= STATUS_RESET[3:0];
      errDetail_q <= '0;
      idStatus_q <= IDST_NONE;
    end else if (ce) begin
      flags_q[STS_RXOK] <= rxRespDone | (flags_q[STS_RXOK] & ~w1c[STS_RXOK]);
      flags_q[STS_TXOK] <= txRespDone | (flags_q[STS_TXOK] & ~w1c[STS_TXOK]);
      flags_q[STS_IDOK] <= idEvt | (ctrlMaster_q & txHeaderDone)
                           | (flags_q[STS_IDOK] & ~w1c[STS_IDOK]);
      errDetail_q <= (errDetail_q & ~{8{w1c[STS_ERR]}})
                     | {1'b0, byteDone & frameBad & byteOn_q, syncBad, 5'(errSet)};
      flags_q[STS_ERR] <= (|errSet) | syncBad | (byteDone & frameBad)
                          | (flags_q[STS_ERR] & ~w1c[STS_ERR]);
      if (idEvt) begin
        idStatus_q <= idCode(shift_q[5:0]);
      end
    end
  end
  assign statusView = {idStatus_q, (state_q != ST_IDLE) | byteOn_q | txBusy, flags_q};
  // ==========================================================
  // Interrupt output.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(statusView[3:0] & irqEn_q);
    end
  end
  // ==========================================================
  // AHB-Lite slave: zero wait states, write in data phase, read data registered.
  assign busWr = wrPend_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= '0;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wrPend_q <= hsel && htrans[1] && hready && hwrite;
      wrAddr_q <= haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite) begin
        case (haddr[7:0])
          ADDR_CTRL: hrdata <= {30'h0, ctrlMaster_q, ctrlEna_q};
          ADDR_STATUS: hrdata <= {24'h0, statusView};
          ADDR_IRQEN: hrdata <= {28'h0, irqEn_q};
          ADDR_BTR: hrdata <= {24'h0, resyncDisable_q, 1'b0, spb_q};
          ADDR_DIV: hrdata <= 32'(baudDivider_q);
          ADDR_ERR: hrdata <= {24'h0, errDetail_q};
          ADDR_BYTE: hrdata <= {24'h0, lastByte_q};
          default: hrdata <= 32'h0;
        endcase
      end
    end
  end
  // Software control registers.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrlEna_q <= 1'b0;
      ctrlMaster_q <= 1'b0;
      resyncDisable_q <= 1'b0;
      irqEn_q <= '0;
      baudDivider_q <= DIV_W'(DIV_RESET);
    end else if (ce && busWr) begin
      case (wrAddr_q)
        ADDR_CTRL: begin
          ctrlEna_q <= hwdata[CTRL_ENA];
          ctrlMaster_q <= hwdata[CTRL_MASTER];
        end
        ADDR_IRQEN: irqEn_q <= hwdata[3:0];
        ADDR_BTR: resyncDisable_q <= hwdata[BTR_DISR];
        ADDR_DIV: baudDivider_q <= hwdata[DIV_W-1:0];
        default: ctrlEna_q <= ctrlEna_q;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      samplesPerBit <= SPB_DEFAULT;
    end else if (ce) begin
      samplesPerBit <= spb_q;
    end
  end
endmodule
`default_nettype wire

// [sim/lbts_core_chk.sv]
// Port checker of the LIN bit-timing and status block.
`default_nettype none
module lbts_core_chk
  import lbts_pkg::*;
#(
  parameter int DIV_W = 12,
  parameter int ERR_EXT_W = 5
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic txHeaderDone,
  input wire logic txRespDone,
  input wire logic rxRespDone,
  input wire logic [ERR_EXT_W-1:0] errSet,
  input wire logic rxByteValid,
  input wire logic [5:0] samplesPerBit,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Clocking and the two steps of a full status clear.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  sequence wrStatus;
    ce && hsel && htrans[1] && hready && hwrite && haddr[7:0] == ADDR_STATUS;
  endsequence
  sequence clearQuiet;
    ce && hwdata[3:0] == 4'hf && errSet == '0 && !rxRespDone && !txRespDone
      && !txHeaderDone;
  endsequence
  // ==========================================================
  // Assertions on the port behaviour.
  chk_reset_values: assert property (
    $rose(nrst) |-> samplesPerBit == SPB_DEFAULT && !irq && !rxByteValid)
    else $error("outputs not at reset values after release");
  chk_irq_clear: assert property (
    wrStatus ##1 clearQuiet |=> ##1 !irq)
    else $error("irq still high after all flags were cleared");
  chk_spb_floor: assert property (
    samplesPerBit >= SPB_MIN)
    else $error("samples per bit below the minimum");
  chk_spb_restore: assert property (
    ce && rxRespDone |-> ##[1:4] samplesPerBit == SPB_DEFAULT)
    else $error("samples per bit not restored after response");
  chk_rxvalid_pulse: assert property (
    rxByteValid |=> !rxByteValid)
    else $error("byte valid longer than one cycle");
  chk_hrdata_hold: assert property (
    ce && !(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");
  chk_ready_high: assert property (
    hreadyout)
    else $error("ready low");
  chk_resp_okay: assert property (
    !hresp)
    else $error("error response");
endmodule
`default_nettype wire

// [sim/lbts_lin_node.sv]
// Behavioural LIN master node that drives headers onto the receive pin.
`default_nettype none
module lbts_lin_node (
  input wire logic core_clk,
  output var logic linRxd
);
  timeunit 1ns;
  timeprecision 1ps;
  // The bus is recessive high while no frame is sent.
  initial linRxd = 1'b1;
  // Holds the bus at one level for a number of clocks.
  task automatic hold(input logic lvl, input int clks);
    linRxd <= lvl;
    repeat (clks) @(posedge core_clk);
  endtask
  // Sends one byte LSB first between a start and a stop bit.
  task automatic send_byte(input logic [7:0] b, input int bitClk);
    hold(1'b0, bitClk);
    for (int i = 0; i < 8; i++) hold(b[i], bitClk);
    hold(1'b1, bitClk);
  endtask
  task automatic send_header(input int brkBits, input int bitClk, input logic [7:0] pid);
    hold(1'b0, brkBits * bitClk);
    hold(1'b1, bitClk);
    send_byte(8'h55, bitClk);
    send_byte(pid, bitClk);
    hold(1'b1, 2 * bitClk);
  endtask
endmodule
`default_nettype wire

// [sim/lbts_core_test.sv]
// Self-checking bench for the LIN bit-timing and status block.
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
  $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
module lbts_core_test
  import lbts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic txHeaderDone = 1'b0;
  logic txRespDone = 1'b0;
  logic rxRespDone = 1'b0;
  logic [4:0] errSet = 5'h0;
  wire logic hready;
  wire logic [31:0] hrdata;
  wire logic hresp;
  wire logic [7:0] rxByte;
  wire logic rxByteValid;
  wire logic [5:0] samplesPerBit;
  wire logic irq;
  wire logic linRxd;
  int mismatches = 0;
  int check_count = 0;
  int rxCount = 0;
  int n;
  logic [31:0] rdata;
  logic [7:0] lastByte;
  logic [39:0] rstTab [7] = '{{ADDR_CTRL, 32'h0}, {ADDR_STATUS, 32'h0}, {ADDR_IRQEN, 32'h0},
    {ADDR_BTR, 32'h20}, {ADDR_DIV, 32'h0}, {ADDR_ERR, 32'h0}, {8'h1c, 32'h0}};
  logic [2:0] evKind [3] = '{3'h1, 3'h2, 3'h0};
  logic [4:0] evErr [3] = '{5'h0, 5'h0, 5'h1};
  logic [3:0] evSts [3] = '{4'h1, 4'h2, 4'h8};
  int brk [2] = '{10, 29};
  // Free-running 100 MHz clock.
  always #5 core_clk = ~core_clk;
  lbts_core lbts_core_i (
    .core_clk(core_clk), .nrst(nrst), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .linRxd(linRxd),
    .txHeaderDone(txHeaderDone), .txRespDone(txRespDone), .rxRespDone(rxRespDone),
    .respAbort(1'b0), .txBusy(1'b0), .errSet(errSet), .rxByte(rxByte),
    .rxByteValid(rxByteValid), .samplesPerBit(samplesPerBit), .irq(irq)
  );
  lbts_lin_node lbts_lin_node_i (.core_clk(core_clk), .linRxd(linRxd));
  // Counts received bytes and keeps the last one.
  always @(posedge core_clk) if (rxByteValid === 1'b1) begin
    rxCount++;
    lastByte = rxByte;
  end
  // One AHB-Lite single word transfer; read data lands in rdata.
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    rdata = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    `CHK(rdata, exp)
  endtask
  // Pulses the event inputs for one cycle and lets the flags settle.
  task automatic evt(input logic [2:0] e, input logic [4:0] er);
    {txHeaderDone, txRespDone, rxRespDone} <= e;
    errSet <= er;
    @(posedge core_clk);
    {txHeaderDone, txRespDone, rxRespDone} <= 3'h0;
    errSet <= 5'h0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Cuts a hung run short.
  initial begin
    repeat (40000) @(posedge core_clk);
    mismatches++;
    $display("[FAIL] %0t run did not finish", $time);
    close_out();
  end
  // Main test sequence.
  initial begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    foreach (rstTab[i]) rd_chk(rstTab[i][39:32], rstTab[i][31:0]);
    `CHK(samplesPerBit, SPB_DEFAULT)
    $display("test reset done");
    foreach (evKind[i]) begin
      evt(evKind[i], evErr[i]);
      rd_chk(ADDR_STATUS, {28'h0, evSts[i]});
      rd_chk(ADDR_ERR, {27'h0, evErr[i]});
      `CHK(irq, 1'b0)
      wr(ADDR_IRQEN, {28'h0, evSts[i]});
      repeat (2) @(posedge core_clk);
      `CHK(irq, 1'b1)
      wr(ADDR_STATUS, 32'hf);
      rd_chk(ADDR_ERR, 32'h0);
      `CHK(irq, 1'b0)
      wr(ADDR_IRQEN, 32'h0);
    end
    $display("test events done");
    wr(ADDR_DIV, 32'hffff_ffff);
    rd_chk(ADDR_DIV, 32'h0000_0fff);
    wr(ADDR_DIV, 32'h1);
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_IRQEN, 32'h4);
    lastByte = 8'h0;
    lbts_lin_node_i.send_header(13, 72, 8'hfe);
    `CHK(samplesPerBit, 6'h24)
    `CHK(lastByte, 8'hfe)
    rd_chk(ADDR_STATUS, 32'hd4);
    `CHK(irq, 1'b1)
    evt(3'h1, 5'h0);
    `CHK(samplesPerBit, SPB_DEFAULT)
    wr(ADDR_STATUS, 32'hf);
    $display("test header done");
    foreach (brk[i]) begin
      n = rxCount;
      lbts_lin_node_i.send_header(brk[i], 64, 8'hfe);
      `CHK(rxCount, n)
    end
    lbts_lin_node_i.send_header(13, 84, 8'hfe);
    rd_chk(ADDR_ERR, 32'h20);
    bus(ADDR_STATUS, 1'b0, 32'h0);
    `CHK(rdata[3], 1'b1)
    wr(ADDR_STATUS, 32'h8);
    rd_chk(ADDR_ERR, 32'h0);
    $display("test refusals done");
    evt(3'h4, 5'h0);
    bus(ADDR_STATUS, 1'b0, 32'h0);
    `CHK(rdata[2], 1'b0)
    wr(ADDR_CTRL, 32'h3);
    evt(3'h4, 5'h0);
    bus(ADDR_STATUS, 1'b0, 32'h0);
    `CHK(rdata[2], 1'b1)
    lbts_lin_node_i.send_header(13, 72, 8'hfe);
    `CHK(samplesPerBit, SPB_DEFAULT)
    wr(ADDR_STATUS, 32'hf);
    $display("test master done");
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_BTR, 32'h84);
    rd_chk(ADDR_BTR, 32'h88);
    `CHK(samplesPerBit, 6'h08)
    wr(ADDR_BTR, 32'h10);
    bus(ADDR_BTR, 1'b0, 32'h0);
    `CHK(rdata[5:0], 6'h08)
    repeat (2) @(posedge core_clk);
    `CHK(samplesPerBit, SPB_DEFAULT)
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_BTR, 32'h10);
    bus(ADDR_BTR, 1'b0, 32'h0);
    `CHK(rdata[5:0], 6'h10)
    $display("test manual count done");
    close_out();
  end
endmodule
bind lbts_core lbts_core_chk #(.DIV_W(DIV_W), .ERR_EXT_W(ERR_EXT_W)) lbts_core_chk_i (
  .core_clk(core_clk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .txHeaderDone(txHeaderDone),
  .txRespDone(txRespDone), .rxRespDone(rxRespDone), .errSet(errSet),
  .rxByteValid(rxByteValid), .samplesPerBit(samplesPerBit), .irq(irq)
);
`default_nettype wire
